// *** spa_cfg.svh ***
// Constants for the serial programming host controller
// What this block does
// - Leave config space only by re-entry
// - Programmer uses low seven ID bits
// - Read calibration before, verify after programming
// - Accept 0x3FFF as valid calibration value
// - High-voltage-first: clock, data low, then supply
// - High-voltage-first for oscillator 100/101, clear-enable 0
// - Supply-first: supply, pins low, then high voltage
// - Exit: remove supply before high voltage
// - Counter only counts up
// - Six command bits, LSB first, falling edge
// - Data word is sixteen clocks with start/stop
`ifndef SPA_CFG_SVH
`define SPA_CFG_SVH
`define SPA_CMD_LOAD_CONFIG 6'h00
`define SPA_CMD_LOAD_PROG 6'h02
`define SPA_CMD_LOAD_DATA 6'h03
`define SPA_CMD_READ_PROG 6'h04
`define SPA_CMD_READ_DATA 6'h05
`define SPA_CMD_INC_ADDR 6'h06
`define SPA_CMD_BITS 5'h06
`define SPA_WORD_BITS 5'h10
`define SPA_CONFIG_BASE 14'h2000
`define SPA_ADDR_TOP 14'h3FFF
`define SPA_CAL_ERASED 14'h3FFF
`define SPA_ID_MASK 14'h007F
`define SPA_OSC_INT_A 3'h4
`define SPA_OSC_INT_B 3'h5
// Link half period and power step delays in ns at a 5 ns clock
`define SPA_HALF_NS 40
`define SPA_STEP_NS 5000
`define SPA_CLK_NS 5
`define SPA_HALF_CYC (`SPA_HALF_NS / `SPA_CLK_NS)
`define SPA_STEP_CYC ((`SPA_STEP_NS + `SPA_CLK_NS - 1) / `SPA_CLK_NS)
`endif

// *** spa_pkg.sv ***
// Types for the serial programming host controller
package spa_pkg;
    typedef enum logic [6:0] {
        SPA_OFF = 7'h01,
        SPA_ENTER = 7'h02,
        SPA_IDLE = 7'h04,
        SPA_CMD = 7'h08,
        SPA_GAP = 7'h10,
        SPA_WORD = 7'h20,
        SPA_EXIT = 7'h40
    } spa_state_e;
    typedef logic [13:0] spa_addr_t;
endpackage : spa_pkg

// *** spa_shift.sv ***
// Serial clock divider and bit shifter for the programming link
`include "spa_cfg.svh"
module spa_shift #(
    parameter int HALF = `SPA_HALF_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [4:0] nbits,
    input wire logic [15:0] tx,
    input wire logic drive,
    input wire logic data_in,
    output logic busy,
    output logic sclk,
    output logic sdat,
    output logic [15:0] rx
);
    initial begin
        if (HALF < 1 || HALF > 255) $error("spa_shift: HALF out of range");
    end
    logic [7:0] div_r;
    logic [4:0] cnt_r;
    logic [15:0] tx_r;
    logic phase_r;
    wire logic tick = (div_r == 8'(HALF - 1));
    // Data set up on rising edge, sampled by the part on falling
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 8'h00;
            cnt_r <= 5'h00;
            tx_r <= 16'h0000;
            phase_r <= 1'b0;
            busy <= 1'b0;
            sclk <= 1'b0;
            sdat <= 1'b0;
            rx <= 16'h0000;
        end else if (start && !busy) begin
            busy <= 1'b1;
            cnt_r <= nbits;
            tx_r <= tx;
            sdat <= 1'b0;
            div_r <= 8'h00;
            phase_r <= 1'b0;
        end else if (busy) begin
            div_r <= tick ? 8'h00 : div_r + 8'h01;
            if (tick) begin
                phase_r <= ~phase_r;
                if (!phase_r) begin
                    sclk <= 1'b1;
                    sdat <= drive ? tx_r[0] : 1'b0;
                    tx_r <= {1'b0, tx_r[15:1]};
                end else begin
                    sclk <= 1'b0;
                    rx <= {data_in, rx[15:1]};
                    cnt_r <= cnt_r - 5'h01;
                    // Last bit stays on the pin past the falling edge for hold time
                    if (cnt_r == 5'h01) busy <= 1'b0;
                end
            end
        end
    end
endmodule : spa_shift

// *** spa_host.sv ***
// Host controller driving the serial program/verify port
`include "spa_cfg.svh"
module spa_host #(
    parameter int STEP = `SPA_STEP_CYC,
    parameter bit LARGE = 1'b1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enter,
    input wire logic leave,
    input wire logic [2:0] oscillator_select_field,
    input wire logic external_clear_pin_enable,
    input wire logic cmd_valid,
    input wire logic [5:0] cmd_code,
    input wire logic [13:0] cmd_data,
    input wire logic serial_prog_data_pin_in,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [13:0] rsp_data,
    output logic cal_ok,
    output spa_pkg::spa_addr_t pc_shadow,
    output logic in_prog_mode,
    output logic supply_on,
    output logic master_clear_pin,
    output logic serial_prog_clock,
    output logic serial_prog_clock_oe,
    output logic serial_prog_data_pin_out,
    output logic serial_prog_data_pin_oe
);
    import spa_pkg::*;
    initial begin
        if (STEP < 1) $error("spa_host: STEP must be positive");
    end
    ////////////////////////////////////////////////////////////////
    logic rs1_r, rs2_r, din1_r, din2_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rs1_r <= 1'b0;
            rs2_r <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rs2_r <= rs1_r;
        end
    end
    wire logic rstn = rs2_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            din1_r <= 1'b0;
            din2_r <= 1'b0;
        end else begin
            din1_r <= serial_prog_data_pin_in;
            din2_r <= din1_r;
        end
    end
    ////////////////////////////////////////////////////////////////
    function automatic spa_addr_t pc_step(input spa_addr_t pc, input logic big);
        spa_addr_t top;
        top = big ? 14'h1FFF : 14'h0FFF;
        if (pc[13]) pc_step = (pc == `SPA_ADDR_TOP) ? `SPA_CONFIG_BASE : pc + 14'h0001;
        else pc_step = (pc == top) ? 14'h0000 : pc + 14'h0001;
    endfunction : pc_step
    function automatic logic has_data(input logic [5:0] c);
        has_data = (c[3:0] == 4'h0) || (c[3:0] == 4'h2) || (c[3:0] == 4'h3) || (c[3:0] == 4'h4) || (c[3:0] == 4'h5);
    endfunction : has_data
    ////////////////////////////////////////////////////////////////
    spa_state_e st_r, st_nxt;
    logic [15:0] wait_r;
    logic [1:0] step_r;
    logic [5:0] cmd_r;
    logic [13:0] data_r;
    logic sh_start_r;
    logic [4:0] sh_bits_r;
    logic [15:0] sh_tx_r;
    logic sh_drive_r;
    logic hv_first_r;
    logic [1:0] cal_seen_r;
    logic [13:0] cal_ref_r [2];
    wire logic sh_busy;
    wire logic sh_clk;
    wire logic sh_dat;
    wire logic [15:0] sh_rx;
    spa_shift u_shift (
        .clock(clock),
        .rst_n(rstn),
        .start(sh_start_r),
        .nbits(sh_bits_r),
        .tx(sh_tx_r),
        .drive(sh_drive_r),
        .data_in(din2_r),
        .busy(sh_busy),
        .sclk(sh_clk),
        .sdat(sh_dat),
        .rx(sh_rx)
    );
    wire logic wait_done = (wait_r == 16'h0000);
    wire logic is_read = (cmd_r[3:0] == 4'h4) || (cmd_r[3:0] == 4'h5);
    wire logic need_hv_first = ((oscillator_select_field == `SPA_OSC_INT_A) ||
                                (oscillator_select_field == `SPA_OSC_INT_B)) && !external_clear_pin_enable;
    wire logic shift_idle = !sh_busy && !sh_start_r;
    wire logic [13:0] rd_word = sh_rx[14:1];
    wire logic cal_addr = (pc_shadow == 14'h2008) || (pc_shadow == 14'h2009);
    wire logic cal_idx = pc_shadow[0];
    wire logic id_addr = (pc_shadow[13:2] == 12'h800);
    wire logic [13:0] load_word = id_addr ? (data_r & `SPA_ID_MASK) : data_r;
    ////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            SPA_OFF: if (enter) st_nxt = SPA_ENTER;
            SPA_ENTER: if (wait_done && step_r == 2'h2) st_nxt = SPA_IDLE;
            SPA_IDLE: begin
                if (leave) st_nxt = SPA_EXIT;
                else if (cmd_valid) st_nxt = SPA_CMD;
            end
            SPA_CMD: if (shift_idle && wait_done) st_nxt = has_data(cmd_r) ? SPA_GAP : SPA_IDLE;
            SPA_GAP: if (wait_done) st_nxt = SPA_WORD;
            SPA_WORD: if (shift_idle && wait_done) st_nxt = SPA_IDLE;
            SPA_EXIT: if (wait_done && step_r == 2'h1) st_nxt = SPA_OFF;
            default: st_nxt = SPA_OFF;
        endcase
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_r <= SPA_OFF;
            wait_r <= 16'h0000;
            step_r <= 2'h0;
            cmd_r <= 6'h00;
            data_r <= 14'h0000;
            sh_start_r <= 1'b0;
            sh_bits_r <= 5'h00;
            sh_tx_r <= 16'h0000;
            sh_drive_r <= 1'b0;
            hv_first_r <= 1'b0;
            cal_seen_r <= 2'h0;
            cal_ref_r[0] <= 14'h0000;
            cal_ref_r[1] <= 14'h0000;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 14'h0000;
            cal_ok <= 1'b1;
            pc_shadow <= 14'h0000;
            in_prog_mode <= 1'b0;
            supply_on <= 1'b0;
            master_clear_pin <= 1'b0;
        end else begin
            st_r <= st_nxt;
            sh_start_r <= 1'b0;
            rsp_valid <= 1'b0;
            cmd_ready <= (st_nxt == SPA_IDLE);
            if (!wait_done) wait_r <= wait_r - 16'h0001;
            case (st_r)
                SPA_OFF: if (enter) begin
                    hv_first_r <= need_hv_first;
                    step_r <= 2'h0;
                    wait_r <= 16'(STEP);
                    if (need_hv_first) master_clear_pin <= 1'b1;
                    else supply_on <= 1'b1;
                end
                SPA_ENTER: if (wait_done) begin
                    step_r <= step_r + 2'h1;
                    wait_r <= 16'(STEP);
                    if (step_r == 2'h0) begin
                        supply_on <= 1'b1;
                        master_clear_pin <= 1'b1;
                    end else begin
                        in_prog_mode <= 1'b1;
                        pc_shadow <= 14'h0000;
                    end
                end
                SPA_IDLE: if (leave) begin
                    step_r <= 2'h0;
                    wait_r <= 16'(STEP);
                    supply_on <= 1'b0;
                end else if (cmd_valid) begin
                    cmd_r <= cmd_code;
                    data_r <= cmd_data;
                    sh_start_r <= 1'b1;
                    sh_bits_r <= `SPA_CMD_BITS;
                    sh_tx_r <= {10'h000, cmd_code};
                    sh_drive_r <= 1'b1;
                    wait_r <= 16'(STEP);
                end
                SPA_CMD: if (shift_idle && wait_done) begin
                    wait_r <= 16'(STEP);
                    if (cmd_r == `SPA_CMD_LOAD_CONFIG) pc_shadow <= `SPA_CONFIG_BASE;
                    else if (cmd_r == `SPA_CMD_INC_ADDR) pc_shadow <= pc_step(pc_shadow, LARGE);
                end
                SPA_GAP: if (wait_done) begin
                    sh_start_r <= 1'b1;
                    sh_bits_r <= `SPA_WORD_BITS;
                    sh_tx_r <= {1'b0, load_word, 1'b0};
                    sh_drive_r <= !is_read;
                    wait_r <= 16'(STEP);
                end
                SPA_WORD: if (shift_idle && wait_done) begin
                    wait_r <= 16'(STEP);
                    if (is_read) begin
                        rsp_valid <= 1'b1;
                        rsp_data <= rd_word;
                        // First read of each calibration word is its reference; later reads must match
                        if (cal_addr && !cal_seen_r[cal_idx]) begin
                            cal_ref_r[cal_idx] <= rd_word;
                            cal_seen_r[cal_idx] <= 1'b1;
                        end else if (cal_addr) begin
                            // Erased value still counts as valid calibration
                            if (rd_word != cal_ref_r[cal_idx] && rd_word != `SPA_CAL_ERASED) cal_ok <= 1'b0;
                        end
                    end
                end
                SPA_EXIT: if (wait_done) begin
                    step_r <= step_r + 2'h1;
                    wait_r <= 16'(STEP);
                    master_clear_pin <= 1'b0;
                    in_prog_mode <= 1'b0;
                    pc_shadow <= 14'h0000;
                end
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////
    // Pins drive low during entry so the part sees both lines low
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            serial_prog_clock <= 1'b0;
            serial_prog_clock_oe <= 1'b0;
            serial_prog_data_pin_out <= 1'b0;
            serial_prog_data_pin_oe <= 1'b0;
        end else begin
            serial_prog_clock <= sh_clk;
            // Next state used so the pins are driven by the edge that raises high voltage
            serial_prog_clock_oe <= (st_nxt != SPA_OFF);
            serial_prog_data_pin_out <= sh_dat;
            serial_prog_data_pin_oe <= (st_nxt != SPA_OFF) && !(is_read && (st_r == SPA_WORD));
        end
    end
endmodule : spa_host

// *** spa_host_sva.sv ***
// Port-level assertions for the serial programming host controller
module spa_host_sva #(
    parameter bit LARGE = 1'b1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic leave,
    input wire logic [2:0] oscillator_select_field,
    input wire logic external_clear_pin_enable,
    input wire logic cmd_valid,
    input wire logic [5:0] cmd_code,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic cal_ok,
    input wire spa_pkg::spa_addr_t pc_shadow,
    input wire logic in_prog_mode,
    input wire logic supply_on,
    input wire logic master_clear_pin,
    input wire logic serial_prog_clock
);
    import spa_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    logic have_r;
    logic sclk_r;
    logic [3:0] code_r;
    spa_addr_t pc_r;
    logic [4:0] falls_r;
    wire take = cmd_valid && cmd_ready && !leave;
    wire data_cmd = code_r inside {4'h0, 4'h2, 4'h3, 4'h4, 4'h5};
    // Fall seen at this edge is not yet in the counter
    wire [4:0] falls_now = falls_r + {4'h0, sclk_r && !serial_prog_clock};
    wire hv_first = oscillator_select_field inside {3'h4, 3'h5} && !external_clear_pin_enable;
    wire [13:0] top = LARGE ? 14'h1FFF : 14'h0FFF;
    wire [13:0] inc_pc = (pc_r == 14'h3FFF || pc_r == top) ? (pc_r & 14'h2000) : pc_r + 14'h0001;
    ////////////////////////////////////////////////////////////
    always_ff @(posedge clock) sclk_r <= serial_prog_clock;
    // Dropped outside the mode so an entry is never taken for a reply
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            have_r <= 1'b0;
            code_r <= 4'h0;
            pc_r <= 14'h0000;
            falls_r <= 5'h00;
        end else if (take) begin
            have_r <= 1'b1;
            code_r <= cmd_code[3:0];
            pc_r <= pc_shadow;
            falls_r <= 5'h00;
        end else begin
            have_r <= have_r && in_prog_mode;
            falls_r <= falls_r + {4'h0, sclk_r && !serial_prog_clock};
        end
    end
    ////////////////////////////////////////////////////////////
    AST_ENTRY_CLEAR: assert property ($rose(in_prog_mode) |-> pc_shadow == 14'h0000)
        else $error("counter not clear on entry");
    AST_CFG_JUMP: assert property ($rose(cmd_ready) && have_r && code_r == 4'h0 |-> pc_shadow == 14'h2000)
        else $error("config jump missed");
    AST_INC_STEP: assert property ($rose(cmd_ready) && have_r && code_r == 4'h6 |-> pc_shadow == inc_pc)
        else $error("bad increment");
    AST_CFG_STICKY: assert property (in_prog_mode && pc_shadow[13] ##1 in_prog_mode && supply_on |-> pc_shadow[13])
        else $error("left config space");
    AST_UP_ONLY: assert property (in_prog_mode && $past(in_prog_mode) && $changed(pc_shadow) |->
        pc_shadow == $past(pc_shadow) + 14'h0001 || pc_shadow == 14'h0000 || pc_shadow == 14'h2000)
        else $error("counter moved down");
    AST_FRAME_BITS: assert property ($rose(cmd_ready) && have_r |-> falls_now == (data_cmd ? 5'h16 : 5'h06))
        else $error("wrong clock count");
    AST_HV_FIRST: assert property ($rose(supply_on) && hv_first |-> master_clear_pin && !serial_prog_clock)
        else $error("supply before high voltage");
    AST_SUPPLY_FIRST: assert property ($rose(master_clear_pin) && !hv_first |-> supply_on && !serial_prog_clock)
        else $error("high voltage before supply");
    AST_EXIT_ORDER: assert property ($fell(master_clear_pin) |-> !supply_on)
        else $error("supply still on at exit");
    COV_ENTRY: cover property ($rose(in_prog_mode));
    COV_READ: cover property (rsp_valid);
    COV_CAL_BAD: cover property ($fell(cal_ok));
endmodule : spa_host_sva
bind spa_host spa_host_sva #(.LARGE(LARGE)) spa_host_sva_inst (.clock, .rst_n, .leave, .oscillator_select_field,
    .external_clear_pin_enable, .cmd_valid, .cmd_code, .cmd_ready, .rsp_valid, .cal_ok, .pc_shadow,
    .in_prog_mode, .supply_on, .master_clear_pin, .serial_prog_clock);

// *** spa_dev_model.sv ***
// Behavioural program/verify mode device on the far side of the link
module spa_dev_model #(
    parameter bit LARGE = 1'b1,
    parameter logic [13:0] CAL1 = 14'h0000,
    parameter logic [13:0] CAL2 = 14'h0000
) (
    input wire logic sclk,
    input wire logic dat,
    input wire logic vdd,
    input wire logic vpp,
    output logic dev_dat,
    output logic dev_oe,
    output logic [13:0] pc
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [13:0] TOP = LARGE ? 14'h1FFF : 14'h0FFF;
    logic [13:0] mem [int];
    task automatic serve();
        logic [5:0] c;
        logic [15:0] w;
        logic [13:0] v;
        int i;
        for (i = 0; i < 6; i++) begin
            @(negedge sclk) c[i] = dat;
        end
        v = mem.exists(pc) ? mem[pc] : 14'h3FFF;
        if (c[3:0] != 4'h6) begin
            for (i = 0; i < 16; i++) begin
                @(posedge sclk) dev_oe = c[2] && i > 0 && i < 15;
                dev_dat = v[(i + 13) % 14];
                @(negedge sclk) w[i] = dat;
            end
        end
        case (c[3:0])
            4'h0: pc = 14'h2000;
            4'h2: mem[pc] = w[14:1];
            4'h6: pc = (pc == 14'h3FFF || pc == TOP) ? pc & 14'h2000 : pc + 14'h0001;
            default: ;
        endcase
    endtask : serve
    ////////////////////////////////////////////////////////////
    initial begin
        dev_oe = 1'b0;
        dev_dat = 1'b0;
        pc = 14'h0000;
        mem[14'h2008] = CAL1;
        mem[14'h2009] = CAL2;
        forever begin
            wait (vdd && vpp);
            pc = 14'h0000;
            fork
                forever serve();
                wait (!vdd || !vpp);
            join_any
            disable fork;
            dev_oe = 1'b0;
            wait (!vdd && !vpp);
        end
    end
endmodule : spa_dev_model

// *** spa_host_tb_top.sv ***
// Self-checking bench for the serial programming host controller
`include "spa_cfg.svh"
module spa_host_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [13:0] CAL1 = 14'h2A5C;
    localparam logic [13:0] CAL2 = 14'h15A3;
    logic clock = 1'b0, rst_n = 1'b0, enter = 1'b0, leave = 1'b0, cmd_valid = 1'b0;
    logic external_clear_pin_enable = 1'b0, dat_last = 1'b0;
    logic [2:0] oscillator_select_field = 3'h0;
    logic [5:0] cmd_code = 6'h00;
    logic [13:0] cmd_data = 14'h0000;
    logic cmd_ready, rsp_valid, cal_ok, in_prog_mode, supply_on, master_clear_pin;
    logic serial_prog_clock, sclk_oe, sdo, sdo_oe, dev_dat, dev_oe, dat_w;
    logic [13:0] rsp_data, dev_pc, w;
    spa_pkg::spa_addr_t pc_shadow;
    logic [13:0] ref_mem [int];
    int exp_pc, miscompares, samples_checked, n;
    integer seed = 32'hEA16;
    // Released line toggles every clock, starting from the inverse of the last driven bit
    assign dat_w = sdo_oe ? sdo : (dev_oe ? dev_dat : ~dat_last);
    always @(posedge clock) dat_last <= dat_w;
    initial forever #2.5 clock = ~clock;
    spa_host #(.STEP(4), .LARGE(1'b1)) spa_host_inst (.clock, .rst_n, .enter, .leave, .oscillator_select_field,
        .external_clear_pin_enable, .cmd_valid, .cmd_code, .cmd_data, .serial_prog_data_pin_in(dat_w), .cmd_ready,
        .rsp_valid, .rsp_data, .cal_ok, .pc_shadow, .in_prog_mode, .supply_on, .master_clear_pin, .serial_prog_clock,
        .serial_prog_clock_oe(sclk_oe), .serial_prog_data_pin_out(sdo), .serial_prog_data_pin_oe(sdo_oe));
    spa_dev_model #(.LARGE(1'b1), .CAL1(CAL1), .CAL2(CAL2)) spa_dev_model_inst (.sclk(serial_prog_clock),
        .dat(dat_w), .vdd(supply_on), .vpp(master_clear_pin), .dev_dat, .dev_oe, .pc(dev_pc));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : chk
    task automatic results();
        $display("samples_checked=%0d miscompares=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    task automatic tick();
        @(posedge clock);
        #1;
    endtask : tick
    task automatic cmd(input logic [5:0] code, input logic [13:0] data);
        logic [13:0] want;
        for (n = 0; n < 9000 && cmd_ready !== 1'b1; n++) tick();
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_data = data;
        tick();
        cmd_valid = 1'b0;
        for (n = 0; n < 9000 && cmd_ready !== 1'b1; n++) tick();
        chk(cmd_ready, 1'b1);
        want = ref_mem.exists(exp_pc) ? ref_mem[exp_pc] : 14'h3FFF;
        // Reply pulse stands in the cycle in which ready returns
        chk(rsp_valid, (code == `SPA_CMD_READ_PROG) || (code == `SPA_CMD_READ_DATA));
        case (code)
            `SPA_CMD_LOAD_CONFIG: exp_pc = 14'h2000;
            `SPA_CMD_LOAD_PROG: ref_mem[exp_pc] = (exp_pc >= 14'h2000 && exp_pc <= 14'h2003) ? data & 14'h007F : data;
            `SPA_CMD_LOAD_DATA: ;
            `SPA_CMD_INC_ADDR: exp_pc = (exp_pc == 14'h3FFF || exp_pc == 14'h1FFF) ? exp_pc & 14'h2000 : exp_pc + 1;
            default: chk(rsp_data, want);
        endcase
        chk(pc_shadow, exp_pc[13:0]);
        chk(dev_pc, exp_pc[13:0]);
    endtask : cmd
    task automatic mode(input logic [2:0] osc, input logic clr);
        oscillator_select_field = osc;
        external_clear_pin_enable = clr;
        enter = 1'b1;
        for (n = 0; n < 9000 && in_prog_mode !== 1'b1; n++) tick();
        enter = 1'b0;
        exp_pc = 0;
        chk(in_prog_mode, 1'b1);
        chk(sclk_oe, 1'b1);
        chk(pc_shadow, 14'h0000);
    endtask : mode
    task automatic quit();
        leave = 1'b1;
        for (n = 0; n < 9000 && (master_clear_pin !== 1'b0 || supply_on !== 1'b0); n++) tick();
        leave = 1'b0;
        chk(master_clear_pin, 1'b0);
        tick();
    endtask : quit
    task automatic cfg(input int k);
        cmd(`SPA_CMD_LOAD_CONFIG, 14'h0000);
        repeat (k) cmd(`SPA_CMD_INC_ADDR, 14'h0000);
    endtask : cfg
    ////////////////////////////////////////////////////////////
    initial begin
        ref_mem[14'h2008] = CAL1;
        ref_mem[14'h2009] = CAL2;
        repeat (12) @(posedge clock);
        #1;
        rst_n = 1'b1;
        repeat (3) tick();
        chk(cal_ok, 1'b1);
        chk(serial_prog_clock, 1'b0);
        mode(3'h4, 1'b0);
        w = 14'($random(seed));
        cmd(`SPA_CMD_LOAD_PROG, w);
        cmd(`SPA_CMD_LOAD_DATA, 14'($random(seed)));
        repeat (3) cmd(`SPA_CMD_INC_ADDR, 14'h0000);
        quit();
        mode(3'($random(seed)), 1'b1);
        cmd(`SPA_CMD_READ_PROG, 14'h0000);
        cfg(8);
        cmd(`SPA_CMD_READ_PROG, 14'h0000);
        cmd(`SPA_CMD_INC_ADDR, 14'h0000);
        cmd(`SPA_CMD_READ_PROG, 14'h0000);
        chk(cal_ok, 1'b1);
        quit();
        mode(3'h5, 1'b0);
        cfg(0);
        cmd(`SPA_CMD_LOAD_PROG, w);
        repeat (8) cmd(`SPA_CMD_INC_ADDR, 14'h0000);
        cmd(`SPA_CMD_LOAD_PROG, {2'b00, w[11:0]});
        cmd(`SPA_CMD_INC_ADDR, 14'h0000);
        cmd(`SPA_CMD_LOAD_PROG, 14'h3FFF);
        quit();
        mode(3'h4, 1'b0);
        cfg(0);
        cmd(`SPA_CMD_READ_PROG, 14'h0000);
        repeat (9) cmd(`SPA_CMD_INC_ADDR, 14'h0000);
        cmd(`SPA_CMD_READ_PROG, 14'h0000);
        chk(cal_ok, 1'b1);
        quit();
        mode(3'h4, 1'b0);
        cfg(8);
        cmd(`SPA_CMD_READ_PROG, 14'h0000);
        chk(cal_ok, 1'b0);
        quit();
        results();
    end
    initial begin
        #400000;
        miscompares++;
        results();
    end
endmodule : spa_host_tb_top
